// >>> hw/rfh_host.v
// Host controller driving the write and read ports of a 4x4 latch register file
// Operation
// RQ1 - Device keeps four words of four bits; host addresses words 0 to 3.
// RQ2 - Write and read ports are independent; host may write and read together.
// RQ3 - Strobe low loads data into selected word; first select bit is MSB.
// RQ4 - Strobe high leaves all words unchanged whatever the selects are.
// RQ5 - Data is stored true; host writes and reads uninverted bits.
// RQ6 - Selected latches are transparent and follow data while gated.
// RQ7 - Read strobe low drives selected word, output n carries bit n.
// RQ8 - Read strobe high puts all four outputs into high impedance.
// RQ9 - Reads never disturb stored contents.
// RQ10 - Any address present late in the pulse or hold gets written.
// RQ11 - Host sets write selects up before the write strobe falls.
// RQ12 - Host holds the write strobe low at least 25 ns.
// RQ13 - Host waits 25 ns latch time before reading a just-written word.
// RQ14 - Wired-AND depth expansion needs one read port enabled at once.
// RQ15 - Devices may sit side by side sharing selects for width.
// RQ16 - Same word read while written shows incoming data after settling.
// RQ17 - Contents are undefined until written after power-up.
`timescale 1ns/1ns
`include "rfh_map.vh"
module rfh_host (
  input  wire                   clk_i,
  input  wire                   rst_n_i,
  input  wire                   ce_i,
  input  wire                   wr_req_i,
  input  wire [`RFH_ADDR_W-1:0] wr_addr_i,
  input  wire [`RFH_WORD_W-1:0] wr_data_i,
  output reg                    wr_busy_o,
  output reg                    wr_done_o,
  input  wire                   rd_req_i,
  input  wire [`RFH_ADDR_W-1:0] rd_addr_i,
  output reg                    rd_busy_o,
  output reg                    rd_done_o,
  output reg  [`RFH_WORD_W-1:0] rd_data_o,
  output reg  [`RFH_ADDR_W-1:0] wsel_o,
  output reg  [`RFH_WORD_W-1:0] wdata_o,
  output reg                    wstrobe_n_o,
  output reg  [`RFH_ADDR_W-1:0] rsel_o,
  output reg                    rstrobe_n_o,
  input  wire [`RFH_WORD_W-1:0] q_i
);
  // Write sequencer states
  localparam [3:0] W_IDLE  = 4'h1;
  localparam [3:0] W_SETUP = 4'h2;
  localparam [3:0] W_PULSE = 4'h4;
  localparam [3:0] W_HOLD  = 4'h8;
  // Read sequencer states
  localparam [3:0] R_IDLE  = 4'h1;
  localparam [3:0] R_ACC   = 4'h2;
  localparam [3:0] R_OFF   = 4'h4;
  localparam [3:0] R_LATCH = 4'h8;

  // Counts are worked out as integers, then cut to the timer width on purpose
  localparam integer          ASU_C   = `RFH_ASU_CYC;
  localparam integer          WPUL_C  = `RFH_WPULSE_CYC;
  localparam integer          HOLD_C  = (`RFH_DH_CYC > `RFH_AH_CYC) ? `RFH_DH_CYC : `RFH_AH_CYC;
  localparam integer          LATCH_C = `RFH_LATCH_CYC;
  localparam integer          RACC_C  = `RFH_RACC_CYC;
  localparam integer          ROFF_C  = `RFH_ROFF_CYC;
  localparam [`RFH_CNT_W-1:0] ASU_V   = ASU_C[`RFH_CNT_W-1:0];
  localparam [`RFH_CNT_W-1:0] WPUL_V  = WPUL_C[`RFH_CNT_W-1:0];
  localparam [`RFH_CNT_W-1:0] HOLD_V  = HOLD_C[`RFH_CNT_W-1:0];
  localparam [`RFH_CNT_W-1:0] LATCH_V = LATCH_C[`RFH_CNT_W-1:0];
  localparam [`RFH_CNT_W-1:0] RACC_V  = RACC_C[`RFH_CNT_W-1:0];
  localparam [`RFH_CNT_W-1:0] ROFF_V  = ROFF_C[`RFH_CNT_W-1:0];

  reg  [3:0]             wst_reg;
  reg  [3:0]             wst_next;
  reg  [3:0]             rst_reg;
  reg  [3:0]             rst_next;
  reg                    wload;
  reg  [`RFH_CNT_W-1:0]  wval;
  reg                    rload;
  reg  [`RFH_CNT_W-1:0]  rval;
  wire                   wdone;
  wire                   rdone;
  // Word last written, whose latches may still be settling
  reg  [`RFH_ADDR_W-1:0] last_addr_reg;
  reg                    settle_reg;
  wire                   lt_done;
  reg                    lt_load;

  rfh_timer u_wtimer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (wload),
    .value_i (wval),
    .done_o  (wdone)
  );
  rfh_timer u_rtimer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (rload),
    .value_i (rval),
    .done_o  (rdone)
  );
  rfh_timer u_ltimer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .load_i  (lt_load),
    .value_i (LATCH_V),
    .done_o  (lt_done)
  );

  always @* begin
    wst_next = wst_reg;
    wload    = 1'b0;
    wval     = ASU_V;
    lt_load  = 1'b0;
    case (wst_reg)
      W_IDLE: begin
        if (wr_req_i) begin
          wst_next = W_SETUP;
          wload    = 1'b1;
          wval     = ASU_V;
        end
      end
      W_SETUP: begin
        if (wdone) begin
          wst_next = W_PULSE;
          wload    = 1'b1;
          wval     = WPUL_V;
        end
      end
      W_PULSE: begin
        if (wdone) begin
          wst_next = W_HOLD;
          wload    = 1'b1;
          wval     = HOLD_V;
          lt_load  = 1'b1;
        end
      end
      W_HOLD: begin
        if (wdone) begin
          wst_next = W_IDLE;
        end
      end
      default: begin
        wst_next = W_IDLE;
      end
    endcase
  end

  always @* begin
    rst_next = rst_reg;
    rload    = 1'b0;
    rval     = RACC_V;
    case (rst_reg)
      R_IDLE: begin
        if (rd_req_i) begin
          // RQ13 latch time wait
          if (settle_reg && !lt_done && rd_addr_i == last_addr_reg) begin
            rst_next = R_LATCH;
          end else begin
            rst_next = R_ACC;
            rload    = 1'b1;
            rval     = RACC_V;
          end
        end
      end
      R_LATCH: begin
        if (lt_done) begin
          rst_next = R_ACC;
          rload    = 1'b1;
          rval     = RACC_V;
        end
      end
      R_ACC: begin
        if (rdone) begin
          rst_next = R_OFF;
          rload    = 1'b1;
          rval     = ROFF_V;
        end
      end
      R_OFF: begin
        // RQ14 output release
        if (rdone) begin
          rst_next = R_IDLE;
        end
      end
      default: begin
        rst_next = R_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wst_reg       <= W_IDLE;
      rst_reg       <= R_IDLE;
      wsel_o        <= {`RFH_ADDR_W{1'b0}};
      wdata_o       <= {`RFH_WORD_W{1'b0}};
      wstrobe_n_o   <= 1'b1;
      rsel_o        <= {`RFH_ADDR_W{1'b0}};
      rstrobe_n_o   <= 1'b1;
      wr_busy_o     <= 1'b0;
      wr_done_o     <= 1'b0;
      rd_busy_o     <= 1'b0;
      rd_done_o     <= 1'b0;
      rd_data_o     <= {`RFH_WORD_W{1'b0}};
      last_addr_reg <= {`RFH_ADDR_W{1'b0}};
      settle_reg    <= 1'b0;
    end else if (ce_i) begin
      wst_reg   <= wst_next;
      rst_reg   <= rst_next;
      wr_done_o <= 1'b0;
      rd_done_o <= 1'b0;
      if (wst_reg == W_IDLE && wr_req_i) begin
        // RQ11 select setup
        wsel_o    <= wr_addr_i;
        // RQ5 true data
        wdata_o   <= wr_data_i;
        wr_busy_o <= 1'b1;
      end
      // RQ12 strobe width
      if (wst_reg == W_SETUP && wdone) begin
        wstrobe_n_o <= 1'b0;
      end
      // RQ10 selects held stable
      if (wst_reg == W_PULSE && wdone) begin
        wstrobe_n_o   <= 1'b1;
        last_addr_reg <= wsel_o;
        settle_reg    <= 1'b1;
      end
      if (wst_reg == W_HOLD && wdone) begin
        wr_busy_o <= 1'b0;
        wr_done_o <= 1'b1;
      end
      if (rst_reg == R_IDLE && rd_req_i) begin
        // RQ15 one shared select
        rsel_o    <= rd_addr_i;
        rd_busy_o <= 1'b1;
      end
      // RQ7 read drive
      if (rst_next == R_ACC && rst_reg != R_ACC) begin
        rstrobe_n_o <= 1'b0;
      end
      if (rst_reg == R_ACC && rdone) begin
        rd_data_o   <= q_i;
        // RQ8 outputs released
        rstrobe_n_o <= 1'b1;
      end
      if (rst_reg == R_OFF && rdone) begin
        rd_busy_o <= 1'b0;
        rd_done_o <= 1'b1;
      end
    end
  end
endmodule // rfh_host

// >>> hw/rfh_map.vh
// Timing constants and field widths for the register-file host controller
`ifndef RFH_MAP_VH
`define RFH_MAP_VH
`define RFH_CLK_PERIOD_NS   40
`define RFH_WORDS           4
`define RFH_WORD_W          4
`define RFH_ADDR_W          2
// Least write strobe width, ns, and cycles (rounded up)
`define RFH_T_WPULSE_NS     25
`define RFH_WPULSE_CYC      ((`RFH_T_WPULSE_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Least select setup before strobe falls, ns
`define RFH_T_ASU_NS        15
`define RFH_ASU_CYC         ((`RFH_T_ASU_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Least select hold after strobe rises, ns
`define RFH_T_AH_NS         5
`define RFH_AH_CYC          ((`RFH_T_AH_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Least data hold after strobe rises, ns
`define RFH_T_DH_NS         15
`define RFH_DH_CYC          ((`RFH_T_DH_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Least latch settling time, ns
`define RFH_T_LATCH_NS      25
`define RFH_LATCH_CYC       ((`RFH_T_LATCH_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Read enable to output valid, ns (worst of enable, select and data paths)
`define RFH_T_RACC_NS       60
`define RFH_RACC_CYC        ((`RFH_T_RACC_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
// Read enable release to outputs off, ns
`define RFH_T_ROFF_NS       50
`define RFH_ROFF_CYC        ((`RFH_T_ROFF_NS + `RFH_CLK_PERIOD_NS - 1) / `RFH_CLK_PERIOD_NS)
`define RFH_CNT_W           3
`endif

// >>> hw/rfh_timer.v
// Down counter that times each phase of a pin sequence
`timescale 1ns/1ns
`include "rfh_map.vh"
module rfh_timer (
  input  wire                  clk_i,
  input  wire                  rst_n_i,
  input  wire                  ce_i,
  input  wire                  load_i,
  input  wire [`RFH_CNT_W-1:0] value_i,
  output wire                  done_o
);
  reg [`RFH_CNT_W-1:0] cnt_reg;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {`RFH_CNT_W{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        cnt_reg <= value_i;
      end else if (cnt_reg != {`RFH_CNT_W{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(`RFH_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign done_o = (cnt_reg == {`RFH_CNT_W{1'b0}});
endmodule // rfh_timer

// >>> testbench/rfh_dev_model.sv
// Behavioural model of the 4x4 latch register file
`timescale 1ns/1ns
module rfh_dev_model (
  input  wire [1:0] wsel_i,
  input  wire [3:0] wdata_i,
  input  wire       wstrobe_n_i,
  input  wire [1:0] rsel_i,
  input  wire       rstrobe_n_i,
  output wire [3:0] q_o
);
  reg [3:0] word_reg [0:3];
  always @* begin
    if (!wstrobe_n_i) begin
      word_reg[wsel_i] = wdata_i;
    end
  end
  // Released lines show the inverse so a late sample fails
  assign #30 q_o = rstrobe_n_i ? ~word_reg[rsel_i] : word_reg[rsel_i];
endmodule // rfh_dev_model

// >>> testbench/rfh_host_chk.sv
// Assertions on the host controller pins
`timescale 1ns/1ns
module rfh_host_chk (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       ce_i,
  input wire       wr_req_i,
  input wire [1:0] wr_addr_i,
  input wire [3:0] wr_data_i,
  input wire       wr_busy_o,
  input wire       wr_done_o,
  input wire       rd_req_i,
  input wire [1:0] rd_addr_i,
  input wire       rd_busy_o,
  input wire       rd_done_o,
  input wire [3:0] rd_data_o,
  input wire [1:0] wsel_o,
  input wire [3:0] wdata_o,
  input wire       wstrobe_n_o,
  input wire [1:0] rsel_o,
  input wire       rstrobe_n_o,
  input wire [3:0] q_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wtake; ce_i && wr_req_i && !wr_busy_o; endsequence
  sequence s_rtake; ce_i && rd_req_i && !rd_busy_o; endsequence
  sequence s_wpulse; wstrobe_n_o ##1 (!wstrobe_n_o) [*2] ##1 wstrobe_n_o; endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    !rst_n_i |=> wstrobe_n_o && rstrobe_n_o && !wr_busy_o && !rd_busy_o) else $error("not idle");
  a_wr_sequence: assert property (s_wtake |-> ##2
    (wsel_o == $past(wr_addr_i, 2) && wdata_o == $past(wr_data_i, 2)) ##0 s_wpulse)
    else $error("bad write");
  a_sel_stable: assert property ($fell(wstrobe_n_o) |->
    ($stable(wsel_o) && $stable(wdata_o)) [*3]) else $error("select moved");
  a_wr_busy: assert property (!wstrobe_n_o |-> wr_busy_o) else $error("idle strobe");
  a_wr_done: assert property (s_wtake |-> ##[5:7] wr_done_o) else $error("no done");
  a_done_once: assert property (wr_done_o |=> !wr_done_o) else $error("long done");
  a_rd_start: assert property (s_rtake |-> ##2
    rsel_o == $past(rd_addr_i, 2) && !rstrobe_n_o) else $error("bad read");
  a_rd_access: assert property ($fell(rstrobe_n_o) |-> !rstrobe_n_o [*2])
    else $error("short read");
  a_rd_capture: assert property ($rose(rstrobe_n_o) |-> rd_data_o == $past(q_i))
    else $error("bad capture");
  a_rd_finish: assert property ($rose(rstrobe_n_o) |-> ##[1:4] rd_done_o)
    else $error("no read done");
endmodule // rfh_host_chk

// >>> testbench/tb_rfh_host.sv
// Self-checking bench for the register-file host controller
`timescale 1ns/1ns
module tb_rfh_host;
  reg        clk_i = 1'b0;
  reg        rst_n_i = 1'b0;
  reg        ce_i = 1'b1;
  reg        wr_req_i = 1'b0;
  reg        rd_req_i = 1'b0;
  reg  [1:0] wr_addr_i = 2'h0;
  reg  [1:0] rd_addr_i = 2'h0;
  reg  [3:0] wr_data_i = 4'h0;
  wire       wr_busy_o, wr_done_o, rd_busy_o, rd_done_o, wstrobe_n_o, rstrobe_n_o;
  wire [1:0] wsel_o, rsel_o;
  wire [3:0] rd_data_o, wdata_o, q_i;
  integer    err_total = 0;
  integer    samples_checked = 0;
  integer    i;
  always #20 clk_i = ~clk_i;
  rfh_host i_dut (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .wr_req_i    (wr_req_i),
    .wr_addr_i   (wr_addr_i),
    .wr_data_i   (wr_data_i),
    .wr_busy_o   (wr_busy_o),
    .wr_done_o   (wr_done_o),
    .rd_req_i    (rd_req_i),
    .rd_addr_i   (rd_addr_i),
    .rd_busy_o   (rd_busy_o),
    .rd_done_o   (rd_done_o),
    .rd_data_o   (rd_data_o),
    .wsel_o      (wsel_o),
    .wdata_o     (wdata_o),
    .wstrobe_n_o (wstrobe_n_o),
    .rsel_o      (rsel_o),
    .rstrobe_n_o (rstrobe_n_o),
    .q_i         (q_i)
  );
  rfh_dev_model i_dev (.wsel_i(wsel_o), .wdata_i(wdata_o), .wstrobe_n_i(wstrobe_n_o),
    .rsel_i(rsel_o), .rstrobe_n_i(rstrobe_n_o), .q_o(q_i));
  task chk(input [3:0] got, input [3:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Bit pattern differs per word and per bit, so swaps show up
  function [3:0] pat(input [1:0] a);
    pat = {a, ~a};
  endfunction
  // Both requests are raised together; waits until both sides are idle
  task req(input w, input [1:0] wa, input [3:0] wd, input r, input [1:0] ra);
    integer n;
    begin
      @(posedge clk_i);
      wr_req_i <= w;
      wr_addr_i <= wa;
      wr_data_i <= wd;
      rd_req_i <= r;
      rd_addr_i <= ra;
      @(posedge clk_i);
      wr_req_i <= 1'b0;
      rd_req_i <= 1'b0;
      for (n = 0; n < 30 && (n < 2 || wr_busy_o !== 1'b0 || rd_busy_o !== 1'b0); n = n + 1)
        @(posedge clk_i);
      if (n == 30) chk(4'h1, 4'h0);
    end
  endtask
  task t_words;
    begin
      for (i = 0; i < 4; i = i + 1)
        req(1'b1, i[1:0], pat(i[1:0]), 1'b0, 2'h0);
      for (i = 0; i < 4; i = i + 1) begin
        req(1'b0, 2'h0, 4'h0, 1'b1, i[1:0]);
        chk(rd_data_o, pat(i[1:0]));
      end
    end
  endtask
  task t_overlap;
    begin
      req(1'b1, 2'h1, 4'hf, 1'b1, 2'h2);
      chk(rd_data_o, pat(2'h2));
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h1);
      chk(rd_data_o, 4'hf);
    end
  endtask
  task t_refuse;
    begin
      @(posedge clk_i);
      wr_req_i <= 1'b1;
      wr_addr_i <= 2'h2;
      wr_data_i <= 4'h5;
      @(posedge clk_i);
      wr_addr_i <= 2'h3;
      wr_data_i <= 4'ha;
      repeat (2) @(posedge clk_i);
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h3);
      chk(rd_data_o, pat(2'h3));
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h2);
      chk(rd_data_o, 4'h5);
    end
  endtask
  task t_rewrite;
    begin
      req(1'b1, 2'h0, 4'he, 1'b0, 2'h0);
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h0);
      chk(rd_data_o, 4'he);
    end
  endtask
  // The device has no reset, so contents survive the host's reset
  task t_midreset;
    begin
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk({2'h0, wstrobe_n_o, rstrobe_n_o}, 4'h3);
      rst_n_i <= 1'b1;
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h1);
      chk(rd_data_o, 4'hf);
    end
  endtask
  // Read of the word just written is held off, strobe high, until its latches settle
  task t_latch;
    begin
      @(posedge clk_i);
      wr_req_i <= 1'b1;
      wr_addr_i <= 2'h1;
      wr_data_i <= 4'h7;
      @(posedge clk_i);
      wr_req_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd_req_i <= 1'b1;
      rd_addr_i <= 2'h1;
      @(posedge clk_i);
      rd_req_i <= 1'b0;
      @(posedge clk_i);
      chk({3'h0, rstrobe_n_o}, 4'h1);
      req(1'b0, 2'h0, 4'h0, 1'b0, 2'h0);
      chk(rd_data_o, 4'h7);
    end
  endtask
  // With the enable low no request is taken and the stored word stays
  task t_freeze;
    begin
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr_req_i <= 1'b1;
      wr_addr_i <= 2'h3;
      wr_data_i <= 4'h0;
      rd_req_i <= 1'b1;
      rd_addr_i <= 2'h3;
      repeat (3) @(posedge clk_i);
      ce_i <= 1'b1;
      wr_req_i <= 1'b0;
      rd_req_i <= 1'b0;
      chk({wr_busy_o, rd_busy_o, wstrobe_n_o, rstrobe_n_o}, 4'h3);
      req(1'b0, 2'h0, 4'h0, 1'b1, 2'h3);
      chk(rd_data_o, pat(2'h3));
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_words;
    t_overlap;
    t_refuse;
    t_rewrite;
    t_midreset;
    t_latch;
    t_freeze;
    finish_test;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    finish_test;
  end
endmodule // tb_rfh_host
bind rfh_host rfh_host_chk i_chk (
  .clk_i       (clk_i),
  .rst_n_i     (rst_n_i),
  .ce_i        (ce_i),
  .wr_req_i    (wr_req_i),
  .wr_addr_i   (wr_addr_i),
  .wr_data_i   (wr_data_i),
  .wr_busy_o   (wr_busy_o),
  .wr_done_o   (wr_done_o),
  .rd_req_i    (rd_req_i),
  .rd_addr_i   (rd_addr_i),
  .rd_busy_o   (rd_busy_o),
  .rd_done_o   (rd_done_o),
  .rd_data_o   (rd_data_o),
  .wsel_o      (wsel_o),
  .wdata_o     (wdata_o),
  .wstrobe_n_o (wstrobe_n_o),
  .rsel_o      (rsel_o),
  .rstrobe_n_o (rstrobe_n_o),
  .q_i         (q_i)
);
